/* core/integrity_pkg.sv */
package integrity_pkg;

    // Register index inside one status group; the top selects the group.
    localparam logic [2:0] IDX_COND = 3'h0;
    localparam logic [2:0] IDX_RISE = 3'h1;
    localparam logic [2:0] IDX_FALL = 3'h2;
    localparam logic [2:0] IDX_EVENT = 3'h3;
    localparam logic [2:0] IDX_MASK = 3'h4;

    // Select bit that picks the uncalibrated group instead of integrity.
    localparam int GROUP_SEL_BIT = 3;

    // Values after reset of the filter, mask and event registers and the edge history.
    localparam logic [15:0] RISE_RESET = 16'h7FFF;
    localparam logic [15:0] FALL_RESET = 16'h0000;
    localparam logic [15:0] EVENT_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] COND_RESET = 16'h0000;

    // Integrity condition bit positions.
    localparam int BIT_RESERVED = 0;
    localparam int BIT_NO_RESULT = 1;
    localparam int BIT_MEAS_TIMEOUT = 2;
    localparam int BIT_UNCAL_SUM = 3;
    localparam int BIT_IF_ADC_OVER = 4;
    localparam int BIT_ADC_OVER = 5;
    localparam int BIT_ADC_UNDER = 6;
    localparam int BIT_INSUFF_DATA = 7;
    localparam int BIT_ACQ_FAIL = 8;
    localparam int BIT_MEM_FAIL = 9;
    localparam int BIT_AUTO_TRIG_TO = 10;
    localparam int BIT_TRIG_PROBLEM = 11;
    localparam int BIT_TRACE_STALE = 12;
    localparam int BIT_OTHER_TERM = 13;
    localparam int BIT_SET_LIMITED = 14;
    localparam int BIT_ALWAYS_ZERO = 15;

    // Condition bits that are built; a cleared bit reads as zero.
    localparam logic [15:0] INTEG_IMPL_MASK = 16'h7FFE;
    localparam logic [15:0] UNCAL_IMPL_MASK = 16'h7FFF;

    // True when a register index addresses the given register.
    function automatic logic idx_is(input logic [2:0] idx,
                                    input logic [2:0] reg_idx);
        idx_is = (idx == reg_idx);
    endfunction

endpackage

/* core/status_if.sv */
interface status_if;
    logic [2:0] idx;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic summary;

    modport ctrl (output idx, output wr, output rd, output wdata,
                  input rdata, input summary);
    modport grp (input idx, input wr, input rd, input wdata,
                 output rdata, output summary);
endinterface

/* core/cond_sync.sv */
module cond_sync
    import integrity_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] stable_ff;
    logic [W-1:0] nxt_stable;

    // A bit moves only once the second and third stage agree, so a pin
    // that is still settling is never seen as two separate edges.
    assign nxt_stable = (s2_ff & ~(s2_ff ^ s3_ff))
                      | (stable_ff & (s2_ff ^ s3_ff));

    // Three-stage chain; the first stage feeds only the second.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            stable_ff <= '0;
        end else begin
            s1_ff <= i_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            stable_ff <= nxt_stable;
        end
    end

    assign o_sync = stable_ff;

endmodule

/* core/status_group.sv */
module status_group
    import integrity_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [15:0] i_cond,
    status_if.grp bus
);

    logic [15:0] cond_prev_ff;
    logic [15:0] rise_ff;
    logic [15:0] fall_ff;
    logic [15:0] event_ff;
    logic [15:0] mask_ff;
    logic [15:0] nxt_event;
    logic [15:0] rose;
    logic [15:0] fell;
    logic [15:0] qual;
    logic rd_event;
    logic wr_rise;
    logic wr_fall;
    logic wr_mask;

    // Edge qualification against the two filters.
    assign rose = i_cond & ~cond_prev_ff;
    assign fell = ~i_cond & cond_prev_ff;
    assign qual = (rose & rise_ff) | (fell & fall_ff);

    // Access decode; the condition and event registers take no writes.
    assign rd_event = bus.rd & idx_is(bus.idx, IDX_EVENT);
    assign wr_rise = bus.wr & idx_is(bus.idx, IDX_RISE);
    assign wr_fall = bus.wr & idx_is(bus.idx, IDX_FALL);
    assign wr_mask = bus.wr & idx_is(bus.idx, IDX_MASK);

    // A read clears, but an edge in the same cycle survives the clear.
    assign nxt_event = (rd_event ? EVENT_RESET : event_ff) | qual;

    // Read mux; unmapped indices read as zero.
    assign bus.rdata = idx_is(bus.idx, IDX_COND) ? i_cond :
                       idx_is(bus.idx, IDX_RISE) ? rise_ff :
                       idx_is(bus.idx, IDX_FALL) ? fall_ff :
                       idx_is(bus.idx, IDX_EVENT) ? event_ff :
                       idx_is(bus.idx, IDX_MASK) ? mask_ff : 16'h0000;
    assign bus.summary = |(event_ff & mask_ff);

    // Group state.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cond_prev_ff <= COND_RESET;
            rise_ff <= RISE_RESET;
            fall_ff <= FALL_RESET;
            event_ff <= EVENT_RESET;
            mask_ff <= MASK_RESET;
        end else begin
            cond_prev_ff <= i_cond;
            event_ff <= nxt_event;
            if (wr_rise) begin
                rise_ff <= bus.wdata;
            end
            if (wr_fall) begin
                fall_ff <= bus.wdata;
            end
            if (wr_mask) begin
                mask_ff <= bus.wdata;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    a_edge_latches: assert property (
        (qual != 16'h0000) |=> ((event_ff & $past(qual)) == $past(qual)))
        else $error("qualified edge not latched");
    a_rise_filter: assert property (
        ((rose & ~rise_ff & ~event_ff) != 16'h0000 && !rd_event)
        |=> ((event_ff & $past(rose & ~rise_ff & ~event_ff)) == 16'h0000))
        else $error("filtered rising edge latched");
    a_read_clears: assert property (
        rd_event |=> (event_ff == $past(qual)))
        else $error("event read did not clear");
    a_set_wins: assert property (
        (rd_event && qual != 16'h0000) ##1 1'b1 |-> event_ff != 16'h0000)
        else $error("edge lost under read clear");
    a_filter_write: assert property (
        wr_fall |=> fall_ff == $past(bus.wdata))
        else $error("falling filter write lost");
    a_event_sticky: assert property (
        (!rd_event) |=> ((event_ff & $past(event_ff)) == $past(event_ff)))
        else $error("event bit dropped without read");

    c_edge_seen: cover property (qual != 16'h0000);
    c_read_clear: cover property (rd_event && event_ff != 16'h0000);

endmodule

/* core/integrity_status.sv */
module integrity_status
    import integrity_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_no_result,
    input wire logic i_meas_timeout,
    input wire logic i_if_adc_over,
    input wire logic i_adc_over,
    input wire logic i_adc_under,
    input wire logic i_insuff_data,
    input wire logic i_acq_fail,
    input wire logic i_mem_fail,
    input wire logic i_auto_trig_timeout,
    input wire logic i_trig_problem,
    input wire logic i_trace_stale,
    input wire logic i_other_term,
    input wire logic i_setting_limited,
    input wire logic [15:0] i_uncal_cond,
    input wire logic [3:0] i_reg_sel,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_integrity_summary
);

    logic [31:0] pin_raw;
    logic [31:0] pin_sync;
    logic [15:0] integ_cond;
    logic [15:0] uncal_cond;
    logic [15:0] rd_mux;
    logic [15:0] rdata_ff;
    logic rvalid_ff;
    logic sel_uncal;
    logic uncal_summary;

    status_if integ_bus ();
    status_if uncal_bus ();

    // Condition pins gathered at their weights; the spare positions are
    // tied low so one synchroniser covers both groups.
    assign pin_raw = {
        i_uncal_cond,
        1'b0,
        i_setting_limited,
        i_other_term,
        i_trace_stale,
        i_trig_problem,
        i_auto_trig_timeout,
        i_mem_fail,
        i_acq_fail,
        i_insuff_data,
        i_adc_under,
        i_adc_over,
        i_if_adc_over,
        1'b0,
        i_meas_timeout,
        i_no_result,
        1'b0
    };

    cond_sync #(
        .W(32)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_async(pin_raw),
        .o_sync(pin_sync)
    );

    // Live condition vectors; nothing stores them, so no write can touch
    // them. Integrity bits 0 and 15 are forced low and bit 3 is the sub-summary; the uncalibrated vector forces only bit 15.
    assign uncal_cond = pin_sync[31:16] & UNCAL_IMPL_MASK;
    assign integ_cond = {
        1'b0,
        pin_sync[14:4],
        uncal_summary,
        pin_sync[2:1],
        1'b0
    } & INTEG_IMPL_MASK;

    // Register select: bit 3 picks the uncalibrated group.
    assign sel_uncal = i_reg_sel[GROUP_SEL_BIT];

    // Both groups see the same index and data; only the strobes are
    // steered, so a write meant for one group never lands in the other.
    assign integ_bus.idx = i_reg_sel[2:0];
    assign integ_bus.wr = i_reg_wr & ~sel_uncal;
    assign integ_bus.rd = i_reg_rd & ~sel_uncal;
    assign integ_bus.wdata = i_reg_wdata;

    assign uncal_bus.idx = i_reg_sel[2:0];
    assign uncal_bus.wr = i_reg_wr & sel_uncal;
    assign uncal_bus.rd = i_reg_rd & sel_uncal;
    assign uncal_bus.wdata = i_reg_wdata;

    // Same group logic serves both levels of the hierarchy.
    status_group u_integ (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_cond(integ_cond),
        .bus(integ_bus.grp)
    );

    status_group u_uncal (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_cond(uncal_cond),
        .bus(uncal_bus.grp)
    );

    assign uncal_summary = uncal_bus.summary;

    // The answer is the plain 16-bit word; its value equals the decimal
    // sum of the weights of the set bits, so no conversion is needed.
    assign rd_mux = sel_uncal ? uncal_bus.rdata : integ_bus.rdata;

    // Read data is captured in the cycle of the read, the same edge on
    // which the event register clears, so the reply holds the old events.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= i_reg_rd;
            if (i_reg_rd) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_reg_rvalid = rvalid_ff;
    assign o_integrity_summary = integ_bus.summary;

    // Every check runs on the system clock and sleeps while reset is held.
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    a_msb_zero: assert property (integ_cond[BIT_ALWAYS_ZERO] == 1'b0)
        else $error("condition bit 15 not zero");
    a_reserved_zero: assert property (
        i_reg_rd && !sel_uncal && i_reg_sel[2:0] == IDX_COND
        |=> o_reg_rdata[BIT_RESERVED] == 1'b0)
        else $error("reserved bit read as one");
    a_uncal_feeds: assert property (
        integ_cond[BIT_UNCAL_SUM] == uncal_bus.summary)
        else $error("bit 3 does not follow sub-summary");
    a_cond_readback: assert property (
        i_reg_rd && !sel_uncal && i_reg_sel[2:0] == IDX_COND
        |=> o_reg_rvalid && o_reg_rdata == $past(integ_cond))
        else $error("condition read returned wrong word");
    a_cond_ignores_wr: assert property (
        (i_reg_wr && !sel_uncal && i_reg_sel[2:0] == IDX_COND)
        ##1 $stable(pin_sync)
        |-> integ_cond[15:4] == $past(integ_cond[15:4]))
        else $error("write altered condition register");
    a_term_bits: assert property (
        i_no_result [*4] |=> integ_cond[BIT_NO_RESULT])
        else $error("no-result pin not reflected");
    a_timeout_bit: assert property (
        !i_meas_timeout [*4] |=> !integ_cond[BIT_MEAS_TIMEOUT])
        else $error("timeout bit stuck high");
    a_range_bits: assert property (
        (i_adc_over && i_if_adc_over) [*4]
        |=> integ_cond[BIT_ADC_OVER] && integ_cond[BIT_IF_ADC_OVER])
        else $error("range pins not reflected");
    a_trig_bits: assert property (
        (i_auto_trig_timeout && !i_trig_problem) [*4]
        |=> integ_cond[BIT_AUTO_TRIG_TO] && !integ_cond[BIT_TRIG_PROBLEM])
        else $error("trigger bits wrong");
    a_misc_bits: assert property (
        (i_trace_stale && i_setting_limited && i_mem_fail) [*4]
        |=> integ_cond[BIT_TRACE_STALE] && integ_cond[BIT_SET_LIMITED]
            && integ_cond[BIT_MEM_FAIL])
        else $error("status pins not reflected");
    a_event_read_data: assert property (
        i_reg_rd && !sel_uncal && i_reg_sel[2:0] == IDX_EVENT
        |=> o_reg_rdata == $past(integ_bus.rdata))
        else $error("event read lost its contents");
    a_summary_out: assert property (
        integ_bus.wr && i_reg_sel[2:0] == IDX_MASK
        && i_reg_wdata == 16'h0000 |=> !o_integrity_summary)
        else $error("summary stays up with all events masked");

    // A pin needs four steady samples to cross the synchroniser, so each
    // check waits for four before it judges the bit. Both directions are
    // checked, since a bit stuck high is as wrong as one that never sets.
    // Termination causes.
    a_timeout_set: assert property (
        i_meas_timeout [*4]
        |=> integ_cond[BIT_MEAS_TIMEOUT])
        else $error("timeout pin not reflected");

    a_noresult_clr: assert property (
        !i_no_result [*4]
        |=> !integ_cond[BIT_NO_RESULT])
        else $error("no-result bit stuck high");

    a_other_set: assert property (
        i_other_term [*4]
        |=> integ_cond[BIT_OTHER_TERM])
        else $error("other-termination pin not reflected");

    a_other_clr: assert property (
        !i_other_term [*4]
        |=> !integ_cond[BIT_OTHER_TERM])
        else $error("other-termination bit stuck high");

    // Converter range conditions.
    a_under_set: assert property (
        i_adc_under [*4]
        |=> integ_cond[BIT_ADC_UNDER])
        else $error("under-range pin not reflected");

    a_over_clr: assert property (
        !i_adc_over [*4]
        |=> !integ_cond[BIT_ADC_OVER])
        else $error("over-range bit stuck high");

    a_under_clr: assert property (
        !i_adc_under [*4]
        |=> !integ_cond[BIT_ADC_UNDER])
        else $error("under-range bit stuck high");

    a_if_range_clr: assert property (
        !i_if_adc_over [*4]
        |=> !integ_cond[BIT_IF_ADC_OVER])
        else $error("intermediate range bit stuck high");

    // Trigger conditions.
    a_trig_set: assert property (
        i_trig_problem [*4]
        |=> integ_cond[BIT_TRIG_PROBLEM])
        else $error("trigger-problem pin not reflected");

    a_auto_clr: assert property (
        !i_auto_trig_timeout [*4]
        |=> !integ_cond[BIT_AUTO_TRIG_TO])
        else $error("auto-trigger bit stuck high");

    a_trig_clr: assert property (
        !i_trig_problem [*4]
        |=> !integ_cond[BIT_TRIG_PROBLEM])
        else $error("trigger-problem bit stuck high");

    // Data quality and settings conditions.
    a_stale_clr: assert property (
        !i_trace_stale [*4]
        |=> !integ_cond[BIT_TRACE_STALE])
        else $error("stale-trace bit stuck high");

    a_limit_clr: assert property (
        !i_setting_limited [*4]
        |=> !integ_cond[BIT_SET_LIMITED])
        else $error("limited-setting bit stuck high");

    a_data_bits: assert property (
        (i_insuff_data && i_acq_fail) [*4]
        |=> integ_cond[BIT_INSUFF_DATA] && integ_cond[BIT_ACQ_FAIL])
        else $error("data pins not reflected");

    a_insuff_clr: assert property (
        !i_insuff_data [*4]
        |=> !integ_cond[BIT_INSUFF_DATA])
        else $error("insufficient-data bit stuck high");

    a_acq_clr: assert property (
        !i_acq_fail [*4]
        |=> !integ_cond[BIT_ACQ_FAIL])
        else $error("acquisition bit stuck high");

    a_mem_clr: assert property (
        !i_mem_fail [*4]
        |=> !integ_cond[BIT_MEM_FAIL])
        else $error("memory bit stuck high");

    // Uncalibrated group and its path into bit 3.
    a_uncal_follows: assert property (
        i_uncal_cond[0] [*4]
        |=> uncal_cond[0])
        else $error("uncalibrated pin not reflected");

    a_uncal_clr: assert property (
        !i_uncal_cond[0] [*4]
        |=> !uncal_cond[0])
        else $error("uncalibrated bit stuck high");

    a_uncal_msb: assert property (
        i_reg_rd && sel_uncal && i_reg_sel[2:0] == IDX_COND
        |=> o_reg_rdata[BIT_ALWAYS_ZERO] == 1'b0)
        else $error("uncalibrated bit 15 read as one");

    a_uncal_evt_data: assert property (
        i_reg_rd && sel_uncal && i_reg_sel[2:0] == IDX_EVENT
        |=> o_reg_rdata == $past(uncal_bus.rdata))
        else $error("uncalibrated event read lost its contents");

    a_bit3_read: assert property (
        i_reg_rd && !sel_uncal && i_reg_sel[2:0] == IDX_COND
        |=> o_reg_rdata[BIT_UNCAL_SUM] == $past(uncal_summary))
        else $error("bit 3 reads other than the sub-summary");

    // Read answer timing: the strobe comes back exactly one cycle later,
    // and the data word stays put until the next read.
    a_rvalid_pulse: assert property (
        1'b1
        |-> o_reg_rvalid == $past(i_reg_rd))
        else $error("read answer not one cycle after strobe");

    a_rdata_holds: assert property (
        !i_reg_rd
        |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");

    c_summary_up: cover property ($rose(o_integrity_summary));
    c_uncal_chain: cover property ($rose(integ_cond[BIT_UNCAL_SUM]));
    c_event_read: cover property (
        i_reg_rd && i_reg_sel[2:0] == IDX_EVENT ##1 o_reg_rdata != 16'h0000);

endmodule

/* tb/reg_host.sv */
// Behavioural remote controller that issues register queries.
module reg_host (
    input wire logic i_clk_sys,
    input wire logic [15:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    output logic [3:0] o_reg_sel,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [15:0] o_reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle values; the data lines never sit on a stale word.
    initial begin
        o_reg_sel = 4'h0;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 16'h0000;
    end

    // A filter or mask word is the sum of the weights it enables.
    task automatic write(input logic [3:0] sel, input logic [15:0] data);
        @(posedge i_clk_sys);
        #1;
        o_reg_sel = sel;
        o_reg_wdata = data;
        o_reg_wr = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_reg_wr = 1'b0;
        o_reg_wdata = ~data;
    endtask

    // One-cycle read strobe, then a bounded wait for the answer.
    task automatic read(input logic [3:0] sel, output logic [15:0] data,
                        output bit ok);
        ok = 1'b0;
        data = 16'h0000;
        @(posedge i_clk_sys);
        #1;
        o_reg_sel = sel;
        o_reg_rd = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_reg_rd = 1'b0;
        for (int k = 0; k < 4 && !ok; k++) begin
            if (i_reg_rvalid === 1'b1) begin
                data = i_reg_rdata;
                ok = 1'b1;
            end else begin
                @(posedge i_clk_sys);
                #1;
            end
        end
    endtask
endmodule

/* tb/integrity_status_bench.sv */
module integrity_status_bench;
    import integrity_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {logic [15:0] pins; logic [15:0] exp;} row_t;

    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic [15:0] cond_pins = 16'h0000;
    logic [15:0] uncal_pins = 16'h0000;
    logic [3:0] sel;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic summary;
    int n_mismatch = 0;
    int samples_checked = 0;
    // Pin vector uses condition bit positions; bits 0, 3, 15 have no pin.
    row_t rows [14] = '{
        '{16'h0002, 16'h0002}, '{16'h0004, 16'h0004},
        '{16'h0010, 16'h0010}, '{16'h0020, 16'h0020},
        '{16'h0040, 16'h0040}, '{16'h0080, 16'h0080},
        '{16'h0100, 16'h0100}, '{16'h0200, 16'h0200},
        '{16'h0400, 16'h0400}, '{16'h0800, 16'h0800},
        '{16'h1000, 16'h1000}, '{16'h2000, 16'h2000},
        '{16'h4000, 16'h4000}, '{16'h7FF6, 16'h7FF6}};

    integrity_status integrity_status_i (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_no_result(cond_pins[1]),
        .i_meas_timeout(cond_pins[2]),
        .i_if_adc_over(cond_pins[4]),
        .i_adc_over(cond_pins[5]),
        .i_adc_under(cond_pins[6]),
        .i_insuff_data(cond_pins[7]),
        .i_acq_fail(cond_pins[8]),
        .i_mem_fail(cond_pins[9]),
        .i_auto_trig_timeout(cond_pins[10]),
        .i_trig_problem(cond_pins[11]),
        .i_trace_stale(cond_pins[12]),
        .i_other_term(cond_pins[13]),
        .i_setting_limited(cond_pins[14]),
        .i_uncal_cond(uncal_pins),
        .i_reg_sel(sel),
        .i_reg_wr(wr),
        .i_reg_rd(rd),
        .i_reg_wdata(wdata),
        .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid),
        .o_integrity_summary(summary)
    );

    reg_host reg_host_i (
        .i_clk_sys(i_clk_sys),
        .i_reg_rdata(rdata),
        .i_reg_rvalid(rvalid),
        .o_reg_sel(sel),
        .o_reg_wr(wr),
        .o_reg_rd(rd),
        .o_reg_wdata(wdata)
    );

    // 50 MHz system clock.
    initial begin
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // A missing answer counts as a mismatch, not as a hang.
    task automatic expect_reg(input string name, input logic [3:0] s,
                              input logic [15:0] exp);
        logic [15:0] d;
        bit ok;
        reg_host_i.read(s, d, ok);
        if (!ok) begin
            d = 16'hXXXX;
        end
        check(name, d, exp);
    endtask

    // Pins pass a synchroniser, so give them time to settle in.
    task automatic set_pins(input logic [15:0] c, input logic [15:0] u);
        @(posedge i_clk_sys);
        #1;
        cond_pins = c;
        uncal_pins = u;
        repeat (8) @(posedge i_clk_sys);
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The whole run is under five hundred cycles; five thousand is slack.
    initial begin
        #100us;
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge i_clk_sys);
        #1;
        i_nrst = 1'b1;
        // Values after reset, and an unbuilt index.
        expect_reg("rise_rst", {1'b0, IDX_RISE}, RISE_RESET);
        expect_reg("fall_rst", {1'b0, IDX_FALL}, FALL_RESET);
        expect_reg("mask_rst", {1'b0, IDX_MASK}, MASK_RESET);
        expect_reg("event_rst", {1'b0, IDX_EVENT}, EVENT_RESET);
        expect_reg("unmapped", 4'h5, 16'h0000);
        // Each live condition lands in its own weighted bit.
        foreach (rows[i]) begin
            set_pins(rows[i].pins, 16'h0000);
            expect_reg("cond", {1'b0, IDX_COND}, rows[i].exp);
            expect_reg("event", {1'b0, IDX_EVENT}, rows[i].exp);
            set_pins(16'h0000, 16'h0000);
        end
        // Writes to the condition and event places change nothing.
        set_pins(16'h0020, 16'h0000);
        reg_host_i.write({1'b0, IDX_COND}, 16'hFFFF);
        reg_host_i.write({1'b0, IDX_EVENT}, 16'hFFFF);
        expect_reg("cond_ro", {1'b0, IDX_COND}, 16'h0020);
        expect_reg("event_ro", {1'b0, IDX_EVENT}, 16'h0020);
        // Drop the pin while falls are still filtered, then let only
        // falling edges qualify.
        set_pins(16'h0000, 16'h0000);
        reg_host_i.write({1'b0, IDX_RISE}, 16'h0000);
        reg_host_i.write({1'b0, IDX_FALL}, 16'h0020);
        reg_host_i.write({1'b0, IDX_MASK}, 16'h0020);
        expect_reg("fall_rb", {1'b0, IDX_FALL}, 16'h0020);
        set_pins(16'h0020, 16'h0000);
        expect_reg("no_rise", {1'b0, IDX_EVENT}, 16'h0000);
        check("sum_idle", {15'h0000, summary}, 16'h0000);
        set_pins(16'h0000, 16'h0000);
        check("sum_set", {15'h0000, summary}, 16'h0001);
        expect_reg("fall_evt", {1'b0, IDX_EVENT}, 16'h0020);
        expect_reg("cleared", {1'b0, IDX_EVENT}, 16'h0000);
        check("sum_clr", {15'h0000, summary}, 16'h0000);
        // Masked-off events keep the summary low.
        reg_host_i.write({1'b0, IDX_MASK}, 16'h0000);
        set_pins(16'h0020, 16'h0000);
        set_pins(16'h0000, 16'h0000);
        check("sum_mask", {15'h0000, summary}, 16'h0000);
        // Uncalibrated summary feeds bit 3; its bit 15 is ignored.
        reg_host_i.write(4'h8 | {1'b0, IDX_MASK}, 16'h8001);
        set_pins(16'h0000, 16'h8000);
        expect_reg("u_cond", 4'h8 | {1'b0, IDX_COND}, 16'h0000);
        expect_reg("no_bit3", {1'b0, IDX_COND}, 16'h0000);
        set_pins(16'h0000, 16'h8001);
        expect_reg("bit3", {1'b0, IDX_COND}, 16'h0008);
        expect_reg("u_evt", 4'h8 | {1'b0, IDX_EVENT}, 16'h0001);
        expect_reg("bit3_off", {1'b0, IDX_COND}, 16'h0000);
        // A falling edge lands in the very cycle of the event read.
        set_pins(16'h0020, 16'h0000);
        expect_reg("pre_race", {1'b0, IDX_EVENT}, 16'h0020);
        @(posedge i_clk_sys);
        #1;
        cond_pins = 16'h0000;
        repeat (3) @(posedge i_clk_sys);
        expect_reg("race_old", {1'b0, IDX_EVENT}, 16'h0000);
        expect_reg("race_new", {1'b0, IDX_EVENT}, 16'h0020);
        // Reset in mid-run quiets the outputs and restores the registers.
        @(posedge i_clk_sys);
        #1;
        i_nrst = 1'b0;
        #1;
        check("rst_rvalid", {15'h0000, rvalid}, 16'h0000);
        check("rst_rdata", rdata, 16'h0000);
        check("rst_sum", {15'h0000, summary}, 16'h0000);
        repeat (3) @(posedge i_clk_sys);
        #1;
        i_nrst = 1'b1;
        expect_reg("rise_rst2", {1'b0, IDX_RISE}, RISE_RESET);
        expect_reg("event_rst2", {1'b0, IDX_EVENT}, EVENT_RESET);
        test_done();
    end
endmodule
